// ---- verilog/pcr_pkg.sv ----
/*
 * Constants and carrier types for the configuration header register bank,
 * offsets 06h through 13h.
 * Assumes byte offsets inside a 256-byte configuration space, reached as
 * aligned dwords with byte enables.
 */
package pcr_pkg;

    // Byte offsets of the registers
    localparam logic [7:0] PCR_OFS_DEVICE_STATUS    = 8'h06;
    localparam logic [7:0] PCR_OFS_HARDWARE_STEPPING = 8'h08;
    localparam logic [7:0] PCR_OFS_DEVICE_CLASS     = 8'h09;
    localparam logic [7:0] PCR_OFS_CACHE_LINE_LENGTH = 8'h0c;
    localparam logic [7:0] PCR_OFS_BUS_TENURE_TIMER = 8'h0d;
    localparam logic [7:0] PCR_OFS_HEADER_LAYOUT    = 8'h0e;
    localparam logic [7:0] PCR_OFS_SELF_TEST        = 8'h0f;
    localparam logic [7:0] PCR_OFS_WINDOW_BASE_LOW  = 8'h10;

    // Status bit positions
    localparam int PCR_STS_PARITY_ERROR_SEEN      = 15;
    localparam int PCR_STS_SYSTEM_ERROR_SIGNALLED = 14;
    localparam int PCR_STS_MASTER_ABORT_RECEIVED  = 13;
    localparam int PCR_STS_TARGET_ABORT_RECEIVED  = 12;
    localparam int PCR_STS_TARGET_ABORT_SIGNALLED = 11;
    localparam int PCR_STS_SELECT_TIMING_LO       = 9;
    localparam int PCR_STS_MASTER_PARITY_ERROR    = 8;
    localparam int PCR_STS_BACK_TO_BACK_CAPABLE   = 7;
    localparam int PCR_STS_HIGH_SPEED_CAPABLE     = 5;
    localparam int PCR_STS_CAP_LIST_PRESENT       = 4;
    localparam int PCR_STS_IRQ_ASSERTED           = 3;

    // Fixed field values
    localparam logic [7:0] PCR_BASE_CLASS          = 8'h01;
    localparam logic [7:0] PCR_SUB_CLASS           = 8'h08;
    localparam logic [7:0] PCR_PROG_INTERFACE      = 8'h02;
    localparam logic [7:0] PCR_CACHE_LINE_RESET    = 8'h00;
    localparam logic [7:0] PCR_BUS_TENURE_VALUE    = 8'h00;
    localparam logic [6:0] PCR_HEADER_LAYOUT       = 7'h00;
    localparam logic [7:0] PCR_SELF_TEST_ABSENT    = 8'h00;
    localparam logic       PCR_CAP_LIST_PRESENT    = 1'b1;

    // Self-test register fields
    localparam int         PCR_ST_CAPABLE          = 7;
    localparam int         PCR_ST_GO               = 6;
    localparam logic [3:0] PCR_ST_RESULT_RESET     = 4'h0;

    // Window base register fields
    localparam int          PCR_BAR_BASE_LSB       = 14;
    localparam logic        PCR_BAR_PREFETCH_FLAG  = 1'b0;
    localparam logic [1:0]  PCR_BAR_WINDOW_TYPE    = 2'b10;
    localparam logic        PCR_BAR_SPACE_KIND     = 1'b0;
    localparam logic [31:0] PCR_BAR_RESET          = 32'h0000_0000;

    typedef enum logic [0:0] {
        PCR_ST_IDLE    = 1'b0,
        PCR_ST_RUNNING = 1'b1
    } pcr_st_state_t;

    // One configuration access
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcr_cfg_req_t;

    // Error events, one-cycle pulses from the interface logic
    typedef struct packed {
        logic parity_error;
        logic master_abort;
        logic target_abort;
        logic master_parity;
    } pcr_events_t;

    typedef struct packed {
        logic          parity_error_seen;
        logic          master_abort_received;
        logic          target_abort_received;
        logic          master_parity_error;
        logic [7:0]    cache_line_length;
        logic          self_test_go;
        logic [3:0]    self_test_result;
        pcr_st_state_t st_state;
        logic          self_test_start;
        logic [31:0]   window_base;
        logic          cfg_ack;
        logic [31:0]   cfg_rdata;
        logic          parity_error_signal;
    } pcr_state_t;

endpackage

// ---- verilog/pcr_config_header_regs.sv ----
/*
 * Configuration header register bank, offsets 06h-13h: error status,
 * class code, cache line size, latency timer, header type, self-test
 * handshake and the lower memory window base.
 * Assumes one config access per request, dword aligned, with byte
 * enables; events arrive as one-cycle pulses synchronous to clock.
 */
`timescale 1ns/1ps

module pcr_config_header_regs
    import pcr_pkg::*;
#(
    parameter logic [7:0] STEPPING         = 8'h00, // Arbitrary value
    parameter logic       MULTI_FUNCTION   = 1'b0,
    parameter logic [1:0] SELECT_TIMING    = 2'b00,
    parameter logic       BACK_TO_BACK     = 1'b0,
    parameter logic       HIGH_SPEED       = 1'b0,
    parameter logic       SELF_TEST_PRESENT = 1'b1,
    parameter int         BAR_BASE_LSB     = PCR_BAR_BASE_LSB
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    // Configuration access
    input  wire pcr_cfg_req_t cfg_req,
    output logic              cfg_ack,
    output logic [31:0]       cfg_rdata,
    // Events and levels from the controller
    input  wire pcr_events_t  events,
    input  wire logic         parity_response_enable,
    input  wire logic         irq_asserted,
    output logic              parity_error_signal,
    // Self-test engine
    output logic              self_test_start,
    input  wire logic         self_test_done,
    input  wire logic [3:0]   self_test_code
);

    localparam logic [31:0] BAR_WRITE_MASK =
        32'hffff_ffff << BAR_BASE_LSB;

    pcr_state_t state;
    pcr_state_t next_state;

    logic        hit_status;
    logic        hit_class;
    logic        hit_misc;
    logic        hit_bar;
    logic        wr;
    logic [15:0] status_view;
    logic [7:0]  self_test_view;
    logic [31:0] bar_view;
    logic [3:0]  w1c_clear;

    always_comb begin
        hit_status = cfg_req.addr[7:2] == PCR_OFS_DEVICE_STATUS[7:2];
        hit_class  = cfg_req.addr[7:2] == PCR_OFS_HARDWARE_STEPPING[7:2];
        hit_misc   = cfg_req.addr[7:2] == PCR_OFS_CACHE_LINE_LENGTH[7:2];
        hit_bar    = cfg_req.addr[7:2] == PCR_OFS_WINDOW_BASE_LOW[7:2];
        wr         = cfg_req.valid && cfg_req.write;

        status_view = 16'h0000;
        status_view[PCR_STS_PARITY_ERROR_SEEN]     = state.parity_error_seen;
        status_view[PCR_STS_MASTER_ABORT_RECEIVED] =
            state.master_abort_received;
        status_view[PCR_STS_TARGET_ABORT_RECEIVED] =
            state.target_abort_received;
        status_view[PCR_STS_SELECT_TIMING_LO +: 2] = SELECT_TIMING;
        status_view[PCR_STS_MASTER_PARITY_ERROR]   =
            state.master_parity_error;
        status_view[PCR_STS_BACK_TO_BACK_CAPABLE]  = BACK_TO_BACK;
        status_view[PCR_STS_HIGH_SPEED_CAPABLE]    = HIGH_SPEED;
        status_view[PCR_STS_CAP_LIST_PRESENT]      =
            PCR_CAP_LIST_PRESENT;
        status_view[PCR_STS_IRQ_ASSERTED]          = irq_asserted;

        self_test_view = PCR_SELF_TEST_ABSENT;
        if (SELF_TEST_PRESENT) begin
            self_test_view[PCR_ST_CAPABLE] = 1'b1;
            self_test_view[PCR_ST_GO]      = state.self_test_go;
            self_test_view[3:0]            = state.self_test_result;
        end

        bar_view      = state.window_base & BAR_WRITE_MASK;
        bar_view[3]   = PCR_BAR_PREFETCH_FLAG;
        bar_view[2:1] = PCR_BAR_WINDOW_TYPE;
        bar_view[0]   = PCR_BAR_SPACE_KIND;

        // Ones written to the status half of dword 04h clear flags
        w1c_clear = 4'h0;
        if (wr && hit_status) begin
            if (cfg_req.be[3]) begin
                w1c_clear[3] = cfg_req.wdata[16 + PCR_STS_PARITY_ERROR_SEEN];
                w1c_clear[2] =
                    cfg_req.wdata[16 + PCR_STS_MASTER_ABORT_RECEIVED];
                w1c_clear[1] =
                    cfg_req.wdata[16 + PCR_STS_TARGET_ABORT_RECEIVED];
                // Status bit 8 sits in lane 3 of the dword
                w1c_clear[0] =
                    cfg_req.wdata[16 + PCR_STS_MASTER_PARITY_ERROR];
            end
        end

        next_state = state;
        next_state.self_test_start = 1'b0;

        // Set wins over a coinciding clear
        next_state.parity_error_seen = (state.parity_error_seen &
            ~w1c_clear[3]) | events.parity_error;
        next_state.master_abort_received = (state.master_abort_received &
            ~w1c_clear[2]) | events.master_abort;
        next_state.target_abort_received = (state.target_abort_received &
            ~w1c_clear[1]) | events.target_abort;
        next_state.master_parity_error = (state.master_parity_error &
            ~w1c_clear[0]) |
            (events.master_parity && parity_response_enable);

        next_state.parity_error_signal =
            events.parity_error && parity_response_enable;

        if (wr && hit_misc && cfg_req.be[0]) begin
            next_state.cache_line_length = cfg_req.wdata[7:0];
        end

        if (wr && hit_bar) begin
            for (int b = 0; b < 4; b++) begin
                if (cfg_req.be[b]) begin
                    next_state.window_base[8*b +: 8] =
                        cfg_req.wdata[8*b +: 8] &
                        BAR_WRITE_MASK[8*b +: 8];
                end
            end
        end

        case (state.st_state)
            PCR_ST_IDLE: begin
                if (SELF_TEST_PRESENT && wr && hit_misc && cfg_req.be[3] &&
                    cfg_req.wdata[24 + PCR_ST_GO]) begin
                    next_state.self_test_go    = 1'b1;
                    next_state.self_test_start = 1'b1;
                    next_state.st_state        = PCR_ST_RUNNING;
                end
            end
            PCR_ST_RUNNING: begin
                if (self_test_done) begin
                    next_state.self_test_go     = 1'b0;
                    next_state.self_test_result = self_test_code;
                    next_state.st_state         = PCR_ST_IDLE;
                end
            end
            default: begin
                next_state.st_state = PCR_ST_IDLE;
            end
        endcase

        next_state.cfg_ack   = cfg_req.valid;
        next_state.cfg_rdata = 32'h0000_0000;
        if (cfg_req.valid && !cfg_req.write) begin
            if (hit_status) begin
                next_state.cfg_rdata = {status_view, 16'h0000};
            end else if (hit_class) begin
                next_state.cfg_rdata = {PCR_BASE_CLASS, PCR_SUB_CLASS,
                    PCR_PROG_INTERFACE, STEPPING};
            end else if (hit_misc) begin
                next_state.cfg_rdata = {self_test_view,
                    MULTI_FUNCTION, PCR_HEADER_LAYOUT,
                    PCR_BUS_TENURE_VALUE,
                    state.cache_line_length};
            end else if (hit_bar) begin
                next_state.cfg_rdata = bar_view;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state                   <= '0;
            state.cache_line_length <= PCR_CACHE_LINE_RESET;
            state.self_test_result  <= PCR_ST_RESULT_RESET;
            state.st_state          <= PCR_ST_IDLE;
            state.window_base       <= PCR_BAR_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_ack             = state.cfg_ack;
    assign cfg_rdata           = state.cfg_rdata;
    assign parity_error_signal = state.parity_error_signal;
    assign self_test_start     = state.self_test_start;

endmodule

// ---- verif/pcr_regs_asserts.sv ----
/* Checker for the config header bank, on its ports only.
   Assumes the bank's default parameters; attached by bind. */
`timescale 1ns/1ps
module pcr_regs_asserts
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         resetn,
    // Watched ports
    input wire pcr_cfg_req_t cfg_req,
    input wire logic         cfg_ack,
    input wire logic [31:0]  cfg_rdata,
    input wire pcr_events_t  events,
    input wire logic         parity_response_enable,
    input wire logic         irq_asserted,
    input wire logic         parity_error_signal,
    input wire logic         self_test_start
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [5:0] dw);
        cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == dw
            ##1 cfg_ack;
    endsequence
    chk_ack_after_req: assert property (cfg_req.valid |=> cfg_ack)
        else $error("no ack after request");
    chk_status_fixed: assert property (s_rd(6'h01) |->
        cfg_rdata[30] == 1'b0 && cfg_rdata[27] == 1'b0 && cfg_rdata[20]
        && cfg_rdata[22] == 1'b0 && cfg_rdata[15:0] == 16'h0000)
        else $error("status fixed bits wrong");
    chk_irq_mirror: assert property (s_rd(6'h01) |->
        cfg_rdata[19] == $past(irq_asserted))
        else $error("irq status bit wrong");
    chk_class_code: assert property (s_rd(6'h02) |->
        cfg_rdata[31:8] == 24'h010802) else $error("class code wrong");
    chk_tenure_layout: assert property (s_rd(6'h03) |->
        cfg_rdata[22:8] == 15'h0000 && cfg_rdata[31]
        && cfg_rdata[29:28] == 2'h0) else $error("misc dword wrong");
    chk_base_low_bits: assert property (s_rd(6'h04) |->
        cfg_rdata[13:0] == 14'h0004) else $error("base low bits wrong");
    chk_perr_drive: assert property (events.parity_error
        && parity_response_enable |=> parity_error_signal)
        else $error("parity signal missing");
    chk_perr_cause: assert property (parity_error_signal |->
        $past(events.parity_error && parity_response_enable))
        else $error("parity signal without cause");
    chk_start_single: assert property (self_test_start |=>
        !self_test_start) else $error("start pulse too long");
endmodule

bind pcr_config_header_regs pcr_regs_asserts u_chk (
    .clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .events(events),
    .parity_response_enable(parity_response_enable),
    .irq_asserted(irq_asserted), .parity_error_signal(parity_error_signal),
    .self_test_start(self_test_start));

// ---- verif/pcr_selftest_model.sv ----
/* Self-test engine model: runs RUN_CYCLES after a start pulse.
   Assumes a one-cycle start pulse; code is junk outside done. */
`timescale 1ns/1ps
module pcr_selftest_model #(parameter int RUN_CYCLES = 6) (
    // Clock and reset
    input wire logic  clock,
    input wire logic  resetn,
    // Engine handshake
    input wire logic  self_test_start,
    output logic      self_test_done,
    output logic [3:0] self_test_code,
    input wire logic [3:0] run_code
);
    int         cnt;
    logic [3:0] last;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt = 0;
            last = 4'h0;
            self_test_done <= 1'b0;
            self_test_code <= 4'h0;
        end else begin
            self_test_done <= 1'b0;
            self_test_code <= ~last;
            if (self_test_start) begin
                cnt = RUN_CYCLES;
            end else if (cnt != 0) begin
                cnt = cnt - 1;
                if (cnt == 0) begin
                    self_test_done <= 1'b1;
                    self_test_code <= run_code;
                    last = run_code;
                end
            end
        end
    end
endmodule

// ---- verif/tb_pci_config_header_regs.sv ----
/* Testbench for the config header bank.
   Assumes the bank's default parameters and the engine model. */
`timescale 1ns/1ps
module tb_pci_config_header_regs
    import pcr_pkg::*;
;
    logic         clock = 0, resetn = 0, pre = 0, irq = 0;
    logic         cfg_ack, perr, st_start, st_done;
    logic [3:0]   st_code, run_code = 4'h0;
    logic [31:0]  cfg_rdata, rd;
    pcr_cfg_req_t cfg_req = '0;
    pcr_events_t  events = '0;
    int           err_count = 0, total_checks = 0;

    pcr_config_header_regs dut (.clock(clock), .resetn(resetn),
        .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .events(events), .parity_response_enable(pre),
        .irq_asserted(irq), .parity_error_signal(perr),
        .self_test_start(st_start), .self_test_done(st_done),
        .self_test_code(st_code));
    pcr_selftest_model eng (.clock(clock), .resetn(resetn),
        .self_test_start(st_start), .self_test_done(st_done),
        .self_test_code(st_code), .run_code(run_code));

    initial forever #20 clock = ~clock;

    task chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One access; events raised by the caller drop with the request
    task xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
              input logic [31:0] d);
        cfg_req = '{1'b1, w, a, be, d};
        @(posedge clock);
        #1;
        cfg_req.valid = 1'b0;
        events = '0;
        rd = cfg_rdata;
        chk("ack", {31'h0, cfg_ack}, 32'h1);
    endtask
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 4'h0, 32'h0);
        chk(what, rd, e);
    endtask
    task pulse(input pcr_events_t e);
        events = e;
        @(posedge clock);
        #1;
        chk("perr", {31'h0, perr}, {31'h0, e.parity_error & pre});
        events = '0;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        #1;
        resetn = 1;
        rdchk("status", 8'h04, 32'h0010_0000);
        rdchk("class", 8'h08, 32'h0108_0200);
        rdchk("misc", 8'h0c, 32'h8000_0000);
        rdchk("base", 8'h10, 32'h0000_0004);
        rdchk("unmapped", 8'h14, 32'h0);
        $display("test reset values done");
        xfer(1'b1, 8'h0c, 4'h7, 32'hffff_ffa5);
        rdchk("misc rw", 8'h0c, 32'h8000_00a5);
        xfer(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
        rdchk("base rw", 8'h10, 32'hffff_c004);
        xfer(1'b1, 8'h08, 4'hf, 32'h0);
        rdchk("class ro", 8'h08, 32'h0108_0200);
        $display("test read write done");
        pre = 1;
        pulse(4'hf);
        rdchk("status set", 8'h04, 32'hb110_0000);
        xfer(1'b1, 8'h04, 4'hc, 32'h0);
        rdchk("zero write", 8'h04, 32'hb110_0000);
        xfer(1'b1, 8'h04, 4'hc, 32'h2000_0000);
        rdchk("one write", 8'h04, 32'h9110_0000);
        xfer(1'b1, 8'h04, 4'h8, 32'h0100_0000);
        rdchk("bit8 clear", 8'h04, 32'h9010_0000);
        events = 4'h8;
        xfer(1'b1, 8'h04, 4'hc, 32'hffff_0000);
        rdchk("set wins", 8'h04, 32'h8010_0000);
        xfer(1'b1, 8'h04, 4'hc, 32'h8000_0000);
        pre = 0;
        irq = 1;
        pulse(4'h9);
        rdchk("gated", 8'h04, 32'h8018_0000);
        irq = 0;
        $display("test status done");
        for (int i = 0; i < 2; i++) begin
            run_code = i[0] ? 4'h5 : 4'h0;
            xfer(1'b1, 8'h0c, 4'h8, 32'h4000_0000);
            rdchk("running", 8'h0c, 32'hc000_00a5);
            repeat (8) @(posedge clock);
            #1;
            rdchk("result", 8'h0c, {4'h8, run_code, 24'ha5});
        end
        $display("test self test done");
        summarize;
    end

    initial begin
        #(40 * 2000);
        err_count++;
        summarize;
    end
endmodule
